// file: pwd_map.svh
`ifndef PWD_MAP_SVH
`define PWD_MAP_SVH
// Register byte addresses on the Avalon-MM slave
`define PWD_CTRL_OFFSET 8'hC0
`define PWD_RELOAD_OFFSET 8'hC4
`define PWD_IRQ_STATUS_OFFSET 8'hC8
`define PWD_IRQ_MASK_OFFSET 8'hCC
// Control field positions
`define PWD_RUN_BIT 0
`define PWD_REFRESH_BIT 1
`define PWD_CAUSE_BIT 2
`define PWD_RST_EN_BIT 3
// Reset values
`define PWD_CTRL_RESET 4'h0
`define PWD_RELOAD_RESET 8'h00
// Internal reset length in clocks
`define PWD_RESET_CLOCKS 5'h14
// Time base period in clocks and prescaler ratio
`define PWD_TIMEBASE_DIV 16'h0019
`define PWD_PRESCALE_DIV 8'h10
`endif

// file: pwd_pkg.sv
package pwd_pkg;
	// Control register image
	typedef struct packed {
		logic rst_en;
		logic cause;
		logic refresh;
		logic run;
	} pwd_ctrl_t;
	// Bus request bundle
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pwd_req_t;
	typedef enum logic [1:0] {PWD_IDLE, PWD_COUNT, PWD_RESET} pwd_state_t;
endpackage

// file: pwd_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwd_map.svh"
// Shared time base followed by the watchdog prescaler
module pwd_prescaler #(
	parameter logic [15:0] TB_DIV = `PWD_TIMEBASE_DIV,
	parameter logic [7:0] PS_DIV = `PWD_PRESCALE_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	input wire logic tb_restart,
	// Tick out
	output logic tick
);
	logic [15:0] tb_cnt;
	logic [7:0] ps_cnt;
	logic tb_tick;
	////////////////////////////////////////////////////////////////
	// Time base; flash restarts stretch the period
	always_ff @(posedge clk) begin
		if (!rst_n || tb_restart) begin
			tb_cnt <= 16'h0000;
			tb_tick <= 1'b0;
		end else if (tb_cnt == TB_DIV - 16'h0001) begin
			tb_cnt <= 16'h0000;
			tb_tick <= 1'b1;
		end else begin
			tb_cnt <= tb_cnt + 16'h0001;
			tb_tick <= 1'b0;
		end
	end
	// Prescaler only runs while enabled
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			ps_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (tb_tick) begin
			if (ps_cnt == PS_DIV - 8'h01) begin
				ps_cnt <= 8'h00;
				tick <= 1'b1;
			end else begin
				ps_cnt <= ps_cnt + 8'h01;
				tick <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule // pwd_prescaler
`default_nettype wire

// file: pwd_watchdog.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "pwd_map.svh"
module pwd_watchdog #(
	parameter int LOW_W = 8,
	parameter logic [15:0] TB_DIV = `PWD_TIMEBASE_DIV,
	parameter logic [7:0] PS_DIV = `PWD_PRESCALE_DIV
) (
	// Clock and external reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core status
	input wire logic core_idle,
	input wire logic core_power_down,
	input wire logic flash_busy,
	// Outputs
	output logic wdt_reset,
	output logic irq
);
	// Full counter width: reload byte above the prescaled low part
	localparam int CW = 8 + LOW_W;
	// Register state
	pwd_pkg::pwd_ctrl_t ctrl;
	logic [7:0] reload;
	logic [CW-1:0] count;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	// Reset pulse sequencer
	pwd_pkg::pwd_state_t state;
	logic [4:0] rst_cnt;
	// Synchronised mode and flash levels
	logic core_idle_s1;
	logic core_idle_s2;
	logic core_pd_s1;
	logic core_pd_s2;
	logic flash_s1;
	logic flash_s2;
	// Bus request and decode
	pwd_pkg::pwd_req_t req;
	logic acc_pending;
	logic wr_ctrl;
	logic wr_reload;
	logic wr_stat;
	logic wr_mask;
	logic [31:0] next_rdata;
	// Counting control
	logic tick;
	logic run_rise;
	logic do_refresh;
	logic timeout;
	logic halted;
	logic cnt_en;

	// Address match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	////////////////////////////////////////////////////////////////
	// Synchronise core mode and flash status inputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_idle_s1 <= 1'b0;
			core_idle_s2 <= 1'b0;
			core_pd_s1 <= 1'b0;
			core_pd_s2 <= 1'b0;
			flash_s1 <= 1'b0;
			flash_s2 <= 1'b0;
		end else begin
			core_idle_s1 <= core_idle;
			core_idle_s2 <= core_idle_s1;
			core_pd_s1 <= core_power_down;
			core_pd_s2 <= core_pd_s1;
			flash_s1 <= flash_busy;
			flash_s2 <= flash_s1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus: one wait cycle, then the access completes
	assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata};
	always_ff @(posedge clk) begin
		if (!rst_n)
			acc_pending <= 1'b0;
		else
			acc_pending <= (req.rd || req.wr) && avs_waitrequest && !acc_pending;
	end
	// Waitrequest high by default, low for the completing cycle
	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !((req.rd || req.wr) && avs_waitrequest && !acc_pending);
	end
	// Write strobes fire on the completing edge only
	assign wr_ctrl = req.wr && !avs_waitrequest && hit(req.addr, `PWD_CTRL_OFFSET);
	assign wr_reload = req.wr && !avs_waitrequest && hit(req.addr, `PWD_RELOAD_OFFSET);
	assign wr_stat = req.wr && !avs_waitrequest && hit(req.addr, `PWD_IRQ_STATUS_OFFSET);
	assign wr_mask = req.wr && !avs_waitrequest && hit(req.addr, `PWD_IRQ_MASK_OFFSET);

	// One wait state, then a single answer cycle
	chk_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
		((req.rd || req.wr) && avs_waitrequest && !acc_pending) |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	// A second low cycle would complete the same access twice
	chk_wait_short: assert property (@(posedge clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for two cycles");

	// Read mux; unmapped reads return zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit(req.addr, `PWD_CTRL_OFFSET))
			next_rdata = {28'h0000000, ctrl};
		else if (hit(req.addr, `PWD_RELOAD_OFFSET))
			next_rdata = {24'h000000, reload};
		else if (hit(req.addr, `PWD_IRQ_STATUS_OFFSET))
			next_rdata = {30'h00000000, irq_status};
		else if (hit(req.addr, `PWD_IRQ_MASK_OFFSET))
			next_rdata = {30'h00000000, irq_mask};
	end
	// Read data registered so it is stable when waitrequest drops
	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else
			avs_readdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////
	// Reload register, writable whether running or not
	always_ff @(posedge clk) begin
		if (!rst_n)
			reload <= `PWD_RELOAD_RESET;
		else if (wr_reload)
			reload <= req.wdata[7:0];
	end

	// Run rising edge by software write counts as activation and reloads the count
	assign run_rise = wr_ctrl && req.wdata[`PWD_RUN_BIT] && !ctrl.run;
	// Refresh needs the request bit already set before the run write
	assign do_refresh = wr_ctrl && req.wdata[`PWD_RUN_BIT] && ctrl.refresh;
	assign halted = core_idle_s2 || core_pd_s2;
	assign cnt_en = ctrl.run && !halted;
	assign timeout = cnt_en && tick && (count == {CW{1'b1}});

	// Halt follows the mode pins through both synchroniser stages
	chk_halt_sync: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(halted) |-> ($past(core_idle, 2) || $past(core_power_down, 2)))
		else $error("halt without idle or power-down");

	// Control register; external reset disables the watchdog
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= `PWD_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl.run <= req.wdata[`PWD_RUN_BIT];
				ctrl.rst_en <= req.wdata[`PWD_RST_EN_BIT];
			end
			// Set-only from software, hardware clears after refresh
			if (do_refresh)
				ctrl.refresh <= 1'b0;
			else if (wr_ctrl && req.wdata[`PWD_REFRESH_BIT])
				ctrl.refresh <= 1'b1;
			// Hardware set wins over software clear
			if (timeout && ctrl.rst_en)
				ctrl.cause <= 1'b1;
			else if (wr_ctrl && !req.wdata[`PWD_CAUSE_BIT])
				ctrl.cause <= 1'b0;
		end
	end

	// Only a control write or external reset may drop the cause flag
	chk_cause_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl.cause && !wr_ctrl) |=> ctrl.cause)
		else $error("cause flag lost without a write");

	////////////////////////////////////////////////////////////////
	// Prescaled tick source
	pwd_prescaler #(
		.TB_DIV(TB_DIV),
		.PS_DIV(PS_DIV)
	) u_prescaler (
		.clk(clk),
		.rst_n(rst_n),
		.enable(cnt_en),
		.tb_restart(flash_s2),
		.tick(tick)
	);

	// A stopped or halted watchdog gets no count ticks
	chk_stop_tick: assert property (@(posedge clk) disable iff (!rst_n)
		!cnt_en |=> !tick)
		else $error("tick while prescaler disabled");
	// Time base held in restart starves the prescaler
	chk_flash_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(flash_s2 && $past(flash_s2) && $past(flash_s2, 2)) |-> !tick)
		else $error("tick during flash restart");

	// Counter: high byte from reload, up-count on ticks
	always_ff @(posedge clk) begin
		if (!rst_n)
			count <= '0;
		else if (run_rise || do_refresh)
			count <= {reload, {LOW_W{1'b0}}};
		else if (cnt_en && tick)
			count <= count + {{(CW-1){1'b0}}, 1'b1};
	end

	// Activation starts at the reload value with an empty low part
	chk_run_load: assert property (@(posedge clk) disable iff (!rst_n)
		run_rise |=> count == {$past(reload), {LOW_W{1'b0}}})
		else $error("activation load wrong");
	// Each tick advances the count by exactly one
	chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
		(cnt_en && tick && !run_rise && !do_refresh)
			|=> count == $past(count) + {{(CW-1){1'b0}}, 1'b1})
		else $error("count step wrong");
	// Overflow wraps to zero, so the next period is a full one
	chk_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(timeout && !do_refresh) |=> count == '0)
		else $error("count did not wrap on timeout");

	////////////////////////////////////////////////////////////////
	// Internal reset pulse sequencer; watchdog keeps running
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= pwd_pkg::PWD_IDLE;
			rst_cnt <= 5'h00;
			wdt_reset <= 1'b0;
		end else begin
			case (state)
				pwd_pkg::PWD_IDLE: begin
					state <= pwd_pkg::PWD_COUNT;
				end
				pwd_pkg::PWD_COUNT: begin
					if (timeout && ctrl.rst_en) begin
						state <= pwd_pkg::PWD_RESET;
						rst_cnt <= `PWD_RESET_CLOCKS - 5'h01;
						wdt_reset <= 1'b1;
					end
				end
				pwd_pkg::PWD_RESET: begin
					if (rst_cnt == 5'h00) begin
						state <= pwd_pkg::PWD_COUNT;
						wdt_reset <= 1'b0;
					end else begin
						rst_cnt <= rst_cnt - 5'h01;
					end
				end
				default: begin
					state <= pwd_pkg::PWD_IDLE;
				end
			endcase
		end
	end

	// A timeout with the reset enabled starts the pulse on the next edge
	chk_reset_start: assert property (@(posedge clk) disable iff (!rst_n)
		(timeout && ctrl.rst_en && state == pwd_pkg::PWD_COUNT) |=> $rose(wdt_reset))
		else $error("enabled timeout gave no reset");
	// With the reset disabled a timeout only reaches the status bit
	chk_reset_suppress: assert property (@(posedge clk) disable iff (!rst_n)
		(timeout && !ctrl.rst_en) |=> !$rose(wdt_reset))
		else $error("reset despite disabled enable");

	////////////////////////////////////////////////////////////////
	// Interrupts: bit0 timeout, bit1 refresh done; set beats clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= 2'h0;
			irq_mask <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~(wr_stat ? req.wdata[1:0] : 2'h0))
				| {do_refresh, timeout};
			if (wr_mask)
				irq_mask <= req.wdata[1:0];
			irq <= |(irq_status & irq_mask);
		end
	end

	// Level output trails the masked status by one register stage
	chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> irq == |$past(irq_status & irq_mask))
		else $error("irq level does not follow masked status");
	// Every timeout is recorded, whether or not the reset is enabled
	chk_status_set: assert property (@(posedge clk) disable iff (!rst_n)
		timeout |=> irq_status[0])
		else $error("timeout not recorded in status");

	////////////////////////////////////////////////////////////////
	// Checks
	// Pulse is high for twenty edges, low on the twenty-first
	chk_reset_length: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wdt_reset) |-> wdt_reset [*8] ##1 wdt_reset [*8]
			##1 wdt_reset [*4] ##1 !wdt_reset)
		else $error("internal reset length wrong");
	chk_reset_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wdt_reset) |-> $past(ctrl.rst_en))
		else $error("reset without enable");
	chk_cause_set: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wdt_reset) |-> ctrl.cause)
		else $error("cause flag not set");
	chk_run_kept: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(wdt_reset) && $past(ctrl.run)) |-> ctrl.run)
		else $error("watchdog stopped by own reset");
	chk_refresh_clear: assert property (@(posedge clk) disable iff (!rst_n)
		do_refresh |=> !ctrl.refresh)
		else $error("refresh bit not cleared");
	chk_refresh_load: assert property (@(posedge clk) disable iff (!rst_n)
		do_refresh |=> count[CW-1:LOW_W] == $past(reload))
		else $error("refresh load wrong");
	chk_no_sw_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl.refresh && !do_refresh) |=> ctrl.refresh)
		else $error("refresh bit cleared by software");
	chk_halt_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(halted && !run_rise && !do_refresh) |=> $stable(count))
		else $error("counter moved while halted");
	chk_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctrl.run && !run_rise) |=> $stable(count))
		else $error("counter moved while stopped");
	chk_reload_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_reload |=> reload == $past(req.wdata[7:0]))
		else $error("reload write lost");
endmodule // pwd_watchdog
`default_nettype wire

// file: pwd_watchdog_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwd_map.svh"
module pwd_watchdog_tb;
	// Bench drive and observe
	logic clk, rst_n, rd, wr, idle, pdn, fbusy, seen_rst;
	logic [7:0] addr;
	logic [31:0] wdata, seed;
	logic [31:0] qd[$];
	logic [31:0] qm[$];
	wire logic [31:0] rdata;
	wire logic wreq, wrst, irq;
	int err_total, num_checks, w;
	localparam logic [7:0] A_C = `PWD_CTRL_OFFSET;
	localparam logic [7:0] A_R = `PWD_RELOAD_OFFSET;
	localparam logic [7:0] A_S = `PWD_IRQ_STATUS_OFFSET;
	localparam logic [7:0] A_M = `PWD_IRQ_MASK_OFFSET;
	// Short dividers: one count tick every 4 clocks
	pwd_watchdog #(.TB_DIV(16'h0002), .PS_DIV(8'h02)) i_pwd_watchdog (.clk(clk), .rst_n(rst_n),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .core_idle(idle),
		.core_power_down(pdn), .flash_busy(fbusy), .wdt_reset(wrst), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Random source with a fixed start
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Compare and count
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One bus cycle, held until waitrequest is seen low at an edge
	task automatic bus(input logic iw, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= iw;
		rd <= !iw;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			err_total++;
			$display("Error at %0t: bus access not answered", $time);
			test_done();
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// A read leaves its expectation in the queue for the monitor
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		qd.push_back(e & m);
		qm.push_back(m);
		bus(1'b0, a, xs());
	endtask
	// Wait for irq up to a bound, then compare its level
	task automatic wait_irq(input int lim, input logic e, output int n);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, irq}, {31'h0, e});
		if (e && n >= lim) test_done();
	endtask
	task automatic pass_time(input int c);
		repeat (c) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Monitor: read data against the oldest note, reset pulse width
	always @(posedge clk) begin
		if (rd && wreq === 1'b0) begin
			if (qd.size() == 0) begin
				err_total++;
				$display("Error at %0t: read answer with no expectation", $time);
			end else begin
				check(rdata & qm.pop_front(), qd.pop_front());
			end
		end
		if (wrst === 1'b1) begin
			w++;
			seen_rst <= 1'b1;
		end else if (w != 0) begin
			check(w, 32'h14);
			w = 0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] d;
		int n;
		rst_n = 1'b0;
		{rd, wr, idle, pdn, fbusy, seen_rst} = 6'h00;
		addr = 8'h00;
		wdata = 32'h0;
		seed = 32'h0001300E;
		{err_total, num_checks, w} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(A_C, 32'h0, 32'hFF);
		rd_reg(A_R, 32'h0, 32'hFF);
		wr_reg(8'hD0, xs());
		rd_reg(8'hD0, 32'h0, 32'hFFFFFFFF);
		$display("Test reset values done");
		for (int i = 0; i < 4; i++) begin
			d = xs();
			wr_reg(A_R, d);
			rd_reg(A_R, d, 32'hFF);
		end
		$display("Test reload register done");
		wr_reg(A_C, 32'h2);
		rd_reg(A_C, 32'h2, 32'hF);
		wr_reg(A_C, 32'h0);
		rd_reg(A_C, 32'h2, 32'hF);
		wr_reg(A_C, 32'h1);
		rd_reg(A_C, 32'h1, 32'hF);
		rd_reg(A_S, 32'h2, 32'h2);
		wr_reg(A_S, 32'h3);
		wr_reg(A_C, 32'h1);
		rd_reg(A_S, 32'h0, 32'h2);
		$display("Test refresh bit done");
		// Full timeout with reset enabled: 256 ticks from FF00
		wr_reg(A_C, 32'h0);
		wr_reg(A_R, 32'hFF);
		wr_reg(A_M, 32'h1);
		wr_reg(A_C, 32'h9);
		wait_irq(1500, 1'b1, n);
		check({31'h0, n >= 1010 && n <= 1040}, 32'h1);
		pass_time(30);
		check({31'h0, seen_rst}, 32'h1);
		rd_reg(A_C, 32'hD, 32'hF);
		wr_reg(A_C, 32'h9);
		rd_reg(A_C, 32'h9, 32'hF);
		wr_reg(A_S, 32'h3);
		pass_time(3);
		check({31'h0, irq}, 32'h0);
		$display("Test timeout reset done");
		// Reset disabled and irq masked: only status records it
		wr_reg(A_M, 32'h0);
		seen_rst = 1'b0;
		wr_reg(A_C, 32'h0);
		wr_reg(A_C, 32'h1);
		wait_irq(1300, 1'b0, n);
		check({31'h0, seen_rst}, 32'h0);
		rd_reg(A_S, 32'h1, 32'h1);
		wr_reg(A_M, 32'h1);
		wait_irq(5, 1'b1, n);
		wr_reg(A_C, 32'h0);
		wr_reg(A_S, 32'h3);
		$display("Test reset disable done");
		// Idle, power down, flash busy hold the count; then a plain stop
		for (int k = 0; k < 4; k++) begin
			idle <= (k == 0);
			pdn <= (k == 1);
			fbusy <= (k == 2);
			wr_reg(A_C, (k == 3) ? 32'h0 : 32'h1);
			wait_irq(1500, 1'b0, n);
			{idle, pdn, fbusy} <= 3'h0;
			if (k < 3) wait_irq(1500, 1'b1, n);
			wr_reg(A_C, 32'h0);
			wr_reg(A_S, 32'h3);
		end
		$display("Test halt modes done");
		// Refresh every 500 clocks keeps a 1024 clock period from expiring
		seen_rst = 1'b0;
		wr_reg(A_C, 32'h9);
		repeat (6) begin
			pass_time(500);
			wr_reg(A_C, 32'hB);
			wr_reg(A_C, 32'h9);
		end
		check({30'h0, irq, seen_rst}, 32'h0);
		$display("Test refresh done");
		// Let it expire once more so the external reset has a cause flag to clear
		wait_irq(1300, 1'b1, n);
		pass_time(30);
		rd_reg(A_C, 32'hD, 32'hF);
		// External reset while running stops the watchdog
		rst_n <= 1'b0;
		pass_time(2);
		rst_n <= 1'b1;
		rd_reg(A_C, 32'h0, 32'hF);
		wait_irq(1300, 1'b0, n);
		rd_reg(A_S, 32'h0, 32'h3);
		$display("Test external reset done");
		test_done();
	end
endmodule // pwd_watchdog_tb
`default_nettype wire
